// file: hdl/gomseq_defines.svh
// Timing counts and field positions for the output mode sequencer.
// Assumes a 125 MHz system clock.
`ifndef GOMSEQ_DEFINES_SVH
`define GOMSEQ_DEFINES_SVH
`define GOMSEQ_CLK_HZ         125000000
`define GOMSEQ_INT_RATE_SPS   2000
`define GOMSEQ_TICK_CYCLES    (`GOMSEQ_CLK_HZ / `GOMSEQ_INT_RATE_SPS)
`define GOMSEQ_ST_INTEGRITY   7
`define GOMSEQ_ST_STARTUP     6
`define GOMSEQ_ST_RANGE       5
`define GOMSEQ_ST_OVERLOAD    4
`define GOMSEQ_ST_CHAN_ERR    3
`define GOMSEQ_ST_CHAN_MSB    2
`define GOMSEQ_BITS_PER_BYTE  10
`define GOMSEQ_IDENT_COUNT    3
`endif

// file: hdl/gomseq_pkg.sv
// Types shared by the output mode sequencer.
// Assumes gomseq_defines.svh is compiled alongside.
package gomseq_pkg;
  typedef enum logic [1:0] {OUT_RATE, OUT_INCR, OUT_AVG, OUT_INTEG} gomseq_out_t;
  typedef enum logic [1:0] {DG_DATA, DG_PART, DG_SERIAL, DG_CONFIG} gomseq_dg_t;
  typedef struct packed {
    gomseq_dg_t        kind;
    logic [7:0]        status;
    logic [23:0]       value;
  } gomseq_dgram_t;
endpackage : gomseq_pkg

// file: hdl/gomseq_fifo.sv
// Datagram request FIFO, width and depth parameterised.
// Assumes one clock; ready/valid on both sides.
`timescale 1ns/10ps
module gomseq_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of two");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_reg != rd_reg;
  assign out_data_o  = mem[rd_reg[AW-1:0]];
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : gomseq_fifo

// file: hdl/gomseq_top.sv
// Mode sequencer and output former of a rate sensor readout.
// Assumes samples arrive per internal tick from the sensing front end and a
// serial transmitter outside signals when a datagram's last bit has left.
`timescale 1ns/10ps
`include "gomseq_defines.svh"
// Summary of operation
// - Reset pin active low; pulled up so floating leaves unit running.
// - Reset pin resets controller and enters initialisation mode.
// - In triggered mode measuring continues at 2000 samples per second.
// - Each falling trigger edge in normal mode sends one datagram with latest data; edges while one is held are ignored.
// - Trigger input pulled high; floating input gives no edges.
// - Requested special datagram waits for next trigger, replacing data.
// - Several special requests before a trigger: only the last is sent.
// - Initialisation sends its three identity datagrams without trigger.
// - Validity strobe falls on the output-rate tick.
// - Validity strobe rises only after the datagram's last bit leaves.
// - In triggered mode the strobe does not mark transmission.
// - Init on power-up, reset pin, reset command, service exit to init.
// - Init waits for references, resets and syncs channels first.
// - Part, serial, config datagrams in order, then normal mode.
// - Normal mode samples at 2000/s, sends at output rate or trigger.
// - Datagrams keep flowing whatever the status byte reports.
// - Entering normal from init sets status bit 6 for a fixed period.
// - Service exit straight to normal skips stabilisation, bit 6 clear.
// - Incremental output sums samples since last send, weighted 1/2000 s.
// - Average output is mean of filtered samples since last send.
// - Rate output sends only newest sample; all two's complement.
// - Status bits: 7 integrity,6 start-up,5 range,4 overload,3 chan,2-0 ZYX.
// - Serial bytes are start, eight data, no parity, stop: ten bits.
module gomseq_top import gomseq_pkg::*; #(
  parameter int          SETTLE_CYCLES  = 125000,
  parameter int          STARTUP_CYCLES = 125000,
  parameter int          SAMPLE_DIV     = 8,
  parameter int          DATA_W         = 24
) (
  input  wire logic          sys_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          hard_reset_n_pin_i,
  input  wire logic          transmit_request_pin_i,
  input  wire logic          triggered_cfg_i,
  input  wire gomseq_out_t   out_mode_i,
  input  wire logic          reset_cmd_i,
  input  wire logic          svc_exit_init_i,
  input  wire logic          svc_exit_normal_i,
  input  wire logic          special_req_i,
  input  wire gomseq_dg_t    special_kind_i,
  input  wire logic [DATA_W-1:0] sample_i,
  input  wire logic [4:0]    fault_flags_i,
  input  wire logic [2:0]    chan_flags_i,
  input  wire logic          tx_done_i,
  output gomseq_dgram_t      dgram_o,
  output logic               dgram_valid_o,
  input  wire logic          dgram_ready_i,
  output logic               validity_strobe_o,
  output logic               normal_mode_o,
  output logic               chan_sync_o
);
  initial if (SAMPLE_DIV < 1 || SAMPLE_DIV > 2000 || DATA_W != 24)
    $error("unsupported parameter");

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Pins idle high; the reset value models the pull-up so nothing fires.
  logic [1:0] rst_sync_reg;
  logic [1:0] trg_sync_reg;
  logic       trg_prev_reg;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rst_sync_reg <= 2'h3;
      trg_sync_reg <= 2'h3;
      trg_prev_reg <= 1'b1;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], hard_reset_n_pin_i};
      trg_sync_reg <= {trg_sync_reg[0], transmit_request_pin_i};
      trg_prev_reg <= trg_sync_reg[1];
    end
  end
  wire pin_reset = !rst_sync_reg[1];
  wire trig_fall = trg_prev_reg && !trg_sync_reg[1];
  wire ctl_rst   = sys_rst_i || pin_reset || reset_cmd_i || svc_exit_init_i;

  // ----------------------------------------------------------------------
  // Internal 2000/s tick and output-rate divider
  // ----------------------------------------------------------------------
  localparam int TICK_W = $clog2(`GOMSEQ_TICK_CYCLES);
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick;
  logic [10:0]       div_cnt_reg;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= '0;
      tick         <= 1'b0;
    end else begin
      tick <= tick_cnt_reg == TICK_W'(`GOMSEQ_TICK_CYCLES - 1);
      if (tick_cnt_reg == TICK_W'(`GOMSEQ_TICK_CYCLES - 1)) tick_cnt_reg <= '0;
      else tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  wire rate_tick = tick && div_cnt_reg == 11'(SAMPLE_DIV - 1);
  always_ff @(posedge sys_clk_i) begin
    if (ctl_rst) div_cnt_reg <= '0;
    else if (tick) div_cnt_reg <= rate_tick ? '0 : div_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {ST_SETTLE, ST_SYNC, ST_IDENT, ST_NORMAL} gomseq_state_t;
  gomseq_state_t state_reg;
  logic [31:0]   wait_reg;
  logic [1:0]    ident_reg;
  logic          startup_reg;
  logic [31:0]   stab_reg;
  wire           fifo_ready;
  logic          push;
  gomseq_dgram_t push_dg;
  always_ff @(posedge sys_clk_i) begin
    if (ctl_rst) begin
      state_reg <= ST_SETTLE;
      wait_reg  <= '0;
      ident_reg <= '0;
    end else begin
      case (state_reg)
        ST_SETTLE: begin
          wait_reg <= wait_reg + 1;
          if (wait_reg == 32'(SETTLE_CYCLES - 1)) state_reg <= ST_SYNC;
        end
        ST_SYNC: begin
          if (tick) state_reg <= ST_IDENT;
        end
        ST_IDENT: begin
          if (fifo_ready) begin
            ident_reg <= ident_reg + 1'b1;
            if (ident_reg == 2'(`GOMSEQ_IDENT_COUNT - 1)) state_reg <= ST_NORMAL;
          end
        end
        ST_NORMAL: state_reg <= ST_NORMAL;
        default:   state_reg <= ST_SETTLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (ctl_rst) begin
      startup_reg <= 1'b0;
      stab_reg    <= '0;
    end else if (svc_exit_normal_i) begin
      startup_reg <= 1'b0;
    end else if (state_reg == ST_IDENT && ident_reg == 2'h2 && fifo_ready) begin
      startup_reg <= 1'b1;
      stab_reg    <= '0;
    end else if (startup_reg) begin
      stab_reg <= stab_reg + 1;
      if (stab_reg == 32'(STARTUP_CYCLES - 1)) startup_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Output forming
  // ----------------------------------------------------------------------
  // Accumulators are widened so incremental sums cannot overflow in a window of up to 2000 ticks.
  logic signed [36:0] sum_reg;
  logic [10:0]        n_reg;
  logic signed [23:0] integ_reg;
  logic signed [23:0] last_reg;
  wire signed [23:0]  smp = sample_i;
  logic               send;
  // Rate scale 2^14 per deg/s, angle 2^21 per deg: sample*2^7/2000 per tick.
  function automatic logic signed [23:0] to_angle(input logic signed [36:0] s);
    logic signed [47:0] w;
    w = 48'(s) * 48'sd128;
    to_angle = 24'(w / 48'sd2000);
  endfunction : to_angle
  always_ff @(posedge sys_clk_i) begin
    if (ctl_rst) begin
      sum_reg   <= '0;
      n_reg     <= '0;
      integ_reg <= '0;
      last_reg  <= '0;
    end else if (tick) begin
      last_reg  <= smp;
      integ_reg <= integ_reg + to_angle(37'(smp));  // wraps naturally
      sum_reg   <= (send ? 37'sd0 : sum_reg) + 37'(smp);
      n_reg     <= (send ? 11'h0 : n_reg) + 1'b1;
    end else if (send) begin
      sum_reg <= '0;
      n_reg   <= '0;
    end
  end
  function automatic logic [23:0] form_value(input gomseq_out_t m);
    case (m)
      OUT_RATE:  form_value = last_reg;
      OUT_INCR:  form_value = to_angle(sum_reg);
      // Divisor kept signed so a negative sum is not divided as unsigned
      OUT_AVG:   form_value = (n_reg == 0) ? last_reg
                                           : 24'(sum_reg / $signed(37'(n_reg)));
      OUT_INTEG: form_value = integ_reg;
      default:   form_value = last_reg;
    endcase
  endfunction : form_value

  // ----------------------------------------------------------------------
  // Datagram scheduling
  // ----------------------------------------------------------------------
  logic       spec_pend_reg;
  gomseq_dg_t spec_kind_reg;
  logic       trig_pend_reg;
  wire        normal = state_reg == ST_NORMAL;
  wire        cue = triggered_cfg_i ? (trig_fall || trig_pend_reg) : rate_tick;
  always_comb begin
    send = normal && cue && fifo_ready;  // status never gates sending
  end
  always_ff @(posedge sys_clk_i) begin
    if (ctl_rst) begin
      spec_pend_reg <= 1'b0;
      spec_kind_reg <= DG_PART;
      trig_pend_reg <= 1'b0;
    end else begin
      if (special_req_i) begin
        spec_pend_reg <= 1'b1;
        spec_kind_reg <= special_kind_i;  // newest overwrites
      end else if (send) begin
        spec_pend_reg <= 1'b0;
      end
      // One stalled trigger is held; further edges while held are ignored.
      if (triggered_cfg_i && trig_fall && normal && !fifo_ready) trig_pend_reg <= 1'b1;
      else if (send) trig_pend_reg <= 1'b0;
    end
  end
  wire [7:0] status = {fault_flags_i[4], startup_reg, fault_flags_i[2:0], chan_flags_i};
  always_comb begin
    push           = 1'b0;
    push_dg.kind   = DG_DATA;
    push_dg.status = status;
    push_dg.value  = form_value(out_mode_i);
    if (state_reg == ST_IDENT) begin
      push         = 1'b1;
      push_dg.kind = gomseq_dg_t'(ident_reg + 2'h1);
    end else if (send) begin
      push = 1'b1;
      if (spec_pend_reg && triggered_cfg_i) push_dg.kind = spec_kind_reg;
      else if (spec_pend_reg) push_dg.kind = spec_kind_reg;
    end
  end

  // Queued datagrams are never touched once pushed, so a late trigger cannot
  // alter the one the serial side is sending.
  gomseq_dgram_t fifo_dg;
  logic          fifo_valid;
  gomseq_fifo #(.WIDTH($bits(gomseq_dgram_t)), .DEPTH(16)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (ctl_rst),
    .in_data_i   (push_dg),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_dg),
    .out_valid_o (fifo_valid),
    .out_ready_i (dgram_ready_i && !(dgram_valid_o))
  );
  // Registered output slot; cleared when the transmitter takes it.
  always_ff @(posedge sys_clk_i) begin
    if (ctl_rst) begin
      dgram_valid_o <= 1'b0;
      dgram_o       <= '0;
    end else if (!dgram_valid_o && fifo_valid && dgram_ready_i) begin
      dgram_valid_o <= 1'b1;
      dgram_o       <= fifo_dg;
    end else if (dgram_valid_o && dgram_ready_i) begin
      dgram_valid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Validity strobe and mode outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (ctl_rst) begin
      validity_strobe_o <= 1'b1;
      normal_mode_o     <= 1'b0;
      chan_sync_o       <= 1'b0;
    end else begin
      normal_mode_o <= normal;
      chan_sync_o   <= state_reg == ST_SYNC && tick;
      // Transmitter frames ten bit times a byte; tx_done_i follows the last stop bit
      if (rate_tick) validity_strobe_o <= 1'b0;
      else if (triggered_cfg_i || tx_done_i) validity_strobe_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_strobe_fall: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    rate_tick |=> !validity_strobe_o) else $error("strobe missed tick");
  chk_strobe_rise: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    $rose(validity_strobe_o) |-> $past(tx_done_i) || $past(triggered_cfg_i))
    else $error("strobe rose early");
  chk_pin_reset: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    pin_reset |=> state_reg == ST_SETTLE) else $error("reset pin ignored");
  chk_trig_send: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    normal && triggered_cfg_i && trig_fall && fifo_ready |-> push)
    else $error("trigger lost");
  chk_no_idle_send: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    normal && triggered_cfg_i && !trig_fall && !trig_pend_reg |-> !push)
    else $error("send without trigger");
  chk_special_kind: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    send && spec_pend_reg |-> push_dg.kind == spec_kind_reg)
    else $error("special datagram not sent");
  chk_startup_bit: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    push |-> push_dg.status[`GOMSEQ_ST_STARTUP] == startup_reg)
    else $error("status start-up bit wrong");
  chk_startup_set: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    $rose(normal) && !$past(svc_exit_normal_i) |-> startup_reg)
    else $error("start-up bit not set on entry");
  chk_svc_skip: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    svc_exit_normal_i |=> !startup_reg) else $error("stabilisation not skipped");
  chk_ident_order: assert property (@(posedge sys_clk_i) disable iff (ctl_rst)
    state_reg == ST_IDENT && ident_reg == 2'h0 && fifo_ready |-> push_dg.kind == DG_PART)
    else $error("identity order wrong");
endmodule : gomseq_top

// file: tb/gomseq_host_model.sv
// Host model: takes datagrams from the sequencer and plays the serial link.
// Assumes the sequencer's single clock and synchronous active-high reset.
`timescale 1ns/10ps
module gomseq_host_model import gomseq_pkg::*; #(
  parameter int DG_BYTES   = 10,
  parameter int BIT_CYCLES = 2
) (
  input  wire logic           sys_clk_i,
  input  wire logic           sys_rst_i,
  input  wire gomseq_dgram_t  dgram_i,
  input  wire logic           dgram_valid_i,
  input  wire logic           stall_i,
  output logic                dgram_ready_o,
  output logic                tx_done_o,
  output gomseq_dgram_t       rx_dgram_o,
  output logic [15:0]         rx_count_o
);
  logic        busy_reg;
  logic [15:0] bits_left_reg;

  // One datagram on the wire at a time; the bench may stall acceptance
  assign dgram_ready_o = !busy_reg && !stall_i;

  always_ff @(posedge sys_clk_i) begin
    tx_done_o <= 1'b0;
    if (sys_rst_i) begin
      busy_reg      <= 1'b0;
      bits_left_reg <= 16'h0000;
      rx_count_o    <= 16'h0000;
      rx_dgram_o    <= '0;
    end else if (busy_reg) begin
      bits_left_reg <= bits_left_reg - 16'h0001;
      if (bits_left_reg == 16'h0001) begin
        busy_reg  <= 1'b0;
        tx_done_o <= 1'b1;
      end
    end else if (dgram_valid_i && dgram_ready_o) begin
      // Every datagram is kept with its status byte, whatever it reports
      rx_dgram_o    <= dgram_i;
      rx_count_o    <= rx_count_o + 16'h0001;
      busy_reg      <= 1'b1;
      bits_left_reg <= 16'(DG_BYTES * 10 * BIT_CYCLES); // Ten bit times a byte
    end
  end
endmodule : gomseq_host_model

// file: tb/tb_top.sv
// Self-checking bench for the output mode sequencer, triggered configuration.
// Assumes the host model in gomseq_host_model.sv; one 125 MHz clock.
`timescale 1ns/10ps
module tb_top import gomseq_pkg::*; ;
  localparam int TICK_WAIT = 70000;
  localparam int DG_WAIT   = 50;
  localparam int TX_SPAN   = 220;
  localparam gomseq_dg_t ID_ORDER [3] = '{DG_PART, DG_SERIAL, DG_CONFIG};
  // One tick of the sample at 2^7/2000 angle counts per rate count, toward zero
  localparam logic [23:0] INTEG_EXP = 24'hf8f91d;

  logic          sys_clk_i  = 1'b0;
  logic          sys_rst_i  = 1'b1;
  logic          rst_n_pin  = 1'b1;
  logic          trig_pin   = 1'b1;
  logic          spec_req   = 1'b0;
  logic          stall      = 1'b0;
  logic          svc_norm   = 1'b0;
  gomseq_out_t   out_mode   = OUT_RATE;
  gomseq_dg_t    spec_kind  = DG_DATA;
  logic [23:0]   sample     = 24'h923456;
  logic [4:0]    fault      = 5'h00;
  logic [2:0]    chan       = 3'h0;
  gomseq_dgram_t dgram;
  gomseq_dgram_t rx_dgram;
  gomseq_dgram_t got;
  logic          dgram_valid;
  logic          dgram_ready;
  logic          tx_done;
  logic          strobe;
  logic          normal;
  logic          chan_sync;
  logic [15:0]   rx_count;
  int            n_errors   = 0;
  int            checked    = 0;
  int            consumed   = 0;
  int            n;

  always #4 sys_clk_i = ~sys_clk_i;

  // Long counts shortened so init fits the run; start-up outlasts identity traffic
  gomseq_top #(.SETTLE_CYCLES(20), .STARTUP_CYCLES(2000), .SAMPLE_DIV(1), .DATA_W(24)) dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .hard_reset_n_pin_i(rst_n_pin),
    .transmit_request_pin_i(trig_pin), .triggered_cfg_i(1'b1), .out_mode_i(out_mode),
    .reset_cmd_i(1'b0), .svc_exit_init_i(1'b0), .svc_exit_normal_i(svc_norm),
    .special_req_i(spec_req), .special_kind_i(spec_kind), .sample_i(sample),
    .fault_flags_i(fault), .chan_flags_i(chan), .tx_done_i(tx_done),
    .dgram_o(dgram), .dgram_valid_o(dgram_valid), .dgram_ready_i(dgram_ready),
    .validity_strobe_o(strobe), .normal_mode_o(normal), .chan_sync_o(chan_sync));

  gomseq_host_model host (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .dgram_i(dgram),
    .dgram_valid_i(dgram_valid), .stall_i(stall), .dgram_ready_o(dgram_ready),
    .tx_done_o(tx_done), .rx_dgram_o(rx_dgram), .rx_count_o(rx_count));

  // ----------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------
  task automatic cmp_vec(input string what, input logic [33:0] exp, input logic [33:0] seen);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp_vec

  task automatic cmp_bit(input string what, input logic exp, input logic seen);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask : cmp_bit

  task automatic get_dg(input string what, output gomseq_dgram_t d);
    int k;
    k = 0;
    while (rx_count <= consumed && k < 3000) begin
      @(negedge sys_clk_i);
      k++;
    end
    cmp_bit(what, 1'b1, rx_count > consumed);
    consumed++;
    d = rx_dgram;
  endtask : get_dg

  task automatic no_more(input string what);
    cmp_vec(what, 34'(consumed), 34'(rx_count));
  endtask : no_more

  task automatic pull_trigger();
    @(negedge sys_clk_i);
    trig_pin = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    trig_pin = 1'b1;
  endtask : pull_trigger

  task automatic ask_special(input gomseq_dg_t kind);
    @(negedge sys_clk_i);
    spec_req  = 1'b1;
    spec_kind = kind;
    @(negedge sys_clk_i);
    spec_req  = 1'b0;
  endtask : ask_special

  task automatic data_dg(input string what, input logic startup);
    pull_trigger();
    get_dg(what, got);
    cmp_vec("data kind", 34'(DG_DATA), 34'(got.kind));
    cmp_vec("status", 34'({fault[4], startup, fault[2:0], chan}), 34'(got.status));
  endtask : data_dg

  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    n = 0;
    while (chan_sync !== 1'b1 && n < TICK_WAIT) begin
      @(negedge sys_clk_i);
      n++;
    end
    cmp_bit("channel sync", 1'b1, chan_sync);
    cmp_bit("strobe falls on tick", 1'b0, strobe);
    no_more("output before sync");
    @(negedge sys_clk_i);
    cmp_bit("strobe back high", 1'b1, strobe);
    for (int i = 0; i < 3; i++) begin
      get_dg("ident datagram", got);
      cmp_vec("ident kind", 34'(ID_ORDER[i]), 34'(got.kind));
    end
    n = 0;
    while (normal !== 1'b1 && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
    end
    cmp_bit("normal mode", 1'b1, normal);
    data_dg("first data", 1'b1);
    // Service exit to normal cuts the start-up period short
    @(negedge sys_clk_i);
    svc_norm = 1'b1;
    @(negedge sys_clk_i);
    svc_norm = 1'b0;
    repeat (20) @(negedge sys_clk_i);
    cmp_bit("strobe in triggered send", 1'b1, strobe);
    repeat (TX_SPAN) @(negedge sys_clk_i);
    no_more("one datagram per edge");
    for (int i = 0; i < 3; i++) begin
      fault = (i == 0) ? 5'h10 : (i == 1) ? 5'h07 : 5'h1f;
      chan  = (i == 0) ? 3'h0 : (i == 1) ? 3'h5 : 3'h7;
      data_dg("flagged data", 1'b0);
      repeat (TX_SPAN) @(negedge sys_clk_i);
    end
    ask_special(DG_PART);
    ask_special(DG_CONFIG);
    repeat (DG_WAIT) @(negedge sys_clk_i);
    no_more("special held");
    pull_trigger();
    get_dg("special sent", got);
    cmp_vec("special kind", 34'(DG_CONFIG), 34'(got.kind));
    repeat (TX_SPAN + DG_WAIT) @(negedge sys_clk_i);
    no_more("earlier special dropped");
    data_dg("data after special", 1'b0);
    repeat (TX_SPAN) @(negedge sys_clk_i);
    stall = 1'b1;
    pull_trigger();
    repeat (DG_WAIT) @(negedge sys_clk_i);
    no_more("host stalled");
    stall = 1'b0;
    get_dg("held after stall", got);
    data_dg("edge during send", 1'b0);
    repeat (TX_SPAN + DG_WAIT) @(negedge sys_clk_i);
    no_more("no extra datagram");
    data_dg("sample data", 1'b0);
    cmp_vec("newest sample", 34'(sample), 34'(got.value));
    repeat (TX_SPAN) @(negedge sys_clk_i);
    out_mode = OUT_INTEG;
    data_dg("integrated data", 1'b0);
    cmp_vec("integrated angle", 34'(INTEG_EXP), 34'(got.value));
    repeat (TX_SPAN) @(negedge sys_clk_i);
    rst_n_pin = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    cmp_bit("normal after reset pin", 1'b0, normal);
    rst_n_pin = 1'b1;
    pull_trigger();
    repeat (TX_SPAN) @(negedge sys_clk_i);
    no_more("no data in init");
    tally_and_finish();
  end

  // One 62500-cycle internal tick plus a few thousand cycles of traffic
  initial begin
    repeat (75000) @(posedge sys_clk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule : tb_top
